// [rtl/dvu_core.sv]
// module: detect-and-vacate user interface and status logic, top level
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps
module dvu_core (
    input wire logic CLOCK,
    input wire logic RST,
    // pins
    input wire logic [3:0] DETECT_LINES,
    input wire logic RESET_BTN,
    input wire logic EMULATE_BTN,
    input wire logic RX_TOGGLE,
    input wire logic [1:0] BOOT_SWITCH,
    input wire logic ASSOC_DONE,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // user outputs
    output logic [3:0] GREEN_LED,
    output logic [3:0] RED_LED,
    output logic [3:0] DIGIT_LEFT,
    output logic [3:0] DIGIT_RIGHT,
    output logic DETECT_STATUS,
    output logic RETUNE_PRIMARY,
    output logic RETUNE_BACKUP,
    output logic ASSOC_ENABLE,
    output logic BRIDGE_ENABLE,
    output logic WIRED_GIGABIT,
    output logic WIRED_AUTO_CROSSOVER,
    output logic IRQ
);
    import dvu_pkg::*;

    dvu_sync_if sync ();
    dvu_state_t state;
    dvu_state_t next_state;
    logic boot_sampled;
    logic [2:0] boot_count;
    logic assoc_on;
    logic vacate_on;
    logic vacate_latched_state;
    logic detect_event;
    logic assoc_sync_meta;
    logic assoc_sync;
    logic [1:0] ctrl;
    logic [IRQ_WIDTH-1:0] irq_stat;
    logic [IRQ_WIDTH-1:0] irq_mask;
    logic [IRQ_WIDTH-1:0] irq_set;
    logic [31:0] rx_count;
    logic [24:0] blink_count;
    logic blink_phase;
    logic apb_access;
    logic apb_read;
    logic apb_write;

    // =========================================================
    // input conditioning
    dvu_input_sync u_sync (
        .clk(CLOCK),
        .rst(RST),
        .lines_pin(DETECT_LINES),
        .reset_btn_pin(RESET_BTN),
        .emulate_btn_pin(EMULATE_BTN),
        .rx_toggle_pin(RX_TOGGLE),
        .switch_pin(BOOT_SWITCH),
        .sync(sync.src)
    );

    // association-complete indication comes from another domain
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            assoc_sync_meta <= 1'b0;
            assoc_sync <= 1'b0;
        end else begin
            assoc_sync_meta <= ASSOC_DONE;
            assoc_sync <= assoc_sync_meta;
        end
    end

    // =========================================================
    // boot switch capture
    // wait a few cycles so the synchroniser holds the real level;
    // later switch movement is ignored until the next reset
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            boot_count <= 3'h0;
            boot_sampled <= 1'b0;
            assoc_on <= 1'b0;
            vacate_on <= 1'b0;
        end else if (!boot_sampled) begin
            boot_count <= boot_count + 3'h1;
            if (boot_count == 3'(BOOT_SAMPLE_CYCLES)) begin
                boot_sampled <= 1'b1;
                assoc_on <= sync.switches[1];
                vacate_on <= sync.switches[0];
            end
        end
    end

    // =========================================================
    // detection source: any line or the emulate button
    // a real or emulated event only counts while vacate is enabled
    // lines are levels, so a line still high on return to ready
    // detects again at once
    assign detect_event = boot_sampled && vacate_on &&
        ((|sync.lines) || sync.emulate_press);

    // vacate state machine
    always_comb begin
        next_state = state;
        case (state)
            ST_DISABLED: begin
                if (boot_sampled && vacate_on) begin
                    next_state = ST_READY;
                end
            end
            ST_READY: begin
                if (detect_event) begin
                    next_state = ST_VACATED;
                end
            end
            ST_VACATED: begin
                if (sync.reset_press) begin
                    next_state = ST_STEP1;
                end
            end
            ST_STEP1: begin
                if (sync.reset_press) begin
                    next_state = ST_READY;
                end
            end
            default: begin
                next_state = ST_DISABLED;
            end
        endcase
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state <= ST_DISABLED;
        end else begin
            state <= next_state;
        end
    end

    assign vacate_latched_state = (state == ST_VACATED);

    // =========================================================
    // radio retune requests and status pin
    // retune to backup completes when software acknowledges it via
    // the ctrl register; the status pin waits for that confirmation
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            RETUNE_BACKUP <= 1'b0;
            RETUNE_PRIMARY <= 1'b0;
            DETECT_STATUS <= 1'b0;
        end else begin
            RETUNE_BACKUP <= (next_state == ST_VACATED);
            RETUNE_PRIMARY <= (next_state != ST_VACATED);
            DETECT_STATUS <= (next_state == ST_VACATED) &&
                ctrl[CTRL_RETUNED_BIT];
        end
    end

    // =========================================================
    // green leds follow the received packet count
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            rx_count <= 32'h0;
            GREEN_LED <= 4'h0;
        end else if (sync.rx_pulse) begin
            rx_count <= rx_count + 32'h1;
            GREEN_LED <= rx_count[3:0] + 4'h1;
        end
    end

    // red led blink timer, one for all four so they stay in step;
    // it restarts on each detection so the leds light at once
    // instead of up to half a period late
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            blink_count <= 25'h0;
            blink_phase <= 1'b0;
        end else if (!vacate_latched_state) begin
            blink_count <= 25'h0;
            blink_phase <= 1'b1;
        end else if (blink_count == 25'(BLINK_CYCLES - 1)) begin
            blink_count <= 25'h0;
            blink_phase <= ~blink_phase;
        end else begin
            blink_count <= blink_count + 25'h1;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            RED_LED <= 4'h0;
        end else begin
            RED_LED <= {4{vacate_latched_state & blink_phase}};
        end
    end

    // =========================================================
    // display: reset step on left digit overrides association code
    // the 2 stays up until the next detection or until association
    // is off, so the user can see the reset completed
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            DIGIT_LEFT <= DIGIT_DASH;
            DIGIT_RIGHT <= DIGIT_DASH;
        end else if (state == ST_STEP1) begin
            DIGIT_LEFT <= DIGIT_ONE;
        end else if (state == ST_READY && sync.reset_press == 1'b0 &&
            DIGIT_LEFT == DIGIT_ONE) begin
            DIGIT_LEFT <= DIGIT_TWO;
        end else if (!assoc_on) begin
            DIGIT_LEFT <= DIGIT_DASH;
            DIGIT_RIGHT <= DIGIT_DASH;
        end else if (DIGIT_LEFT != DIGIT_TWO ||
            state == ST_VACATED) begin
            DIGIT_LEFT <= DIGIT_ZERO;
            DIGIT_RIGHT <= assoc_sync ? DIGIT_ONE : DIGIT_ZERO;
        end else begin
            DIGIT_RIGHT <= assoc_sync ? DIGIT_ONE : DIGIT_ZERO;
        end
    end

    // =========================================================
    // wired bridge configuration
    // the wired port is fixed at gigabit and never swaps pairs;
    // frames are bridged at layer two only, nothing routes here
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ASSOC_ENABLE <= 1'b0;
            BRIDGE_ENABLE <= 1'b0;
            WIRED_GIGABIT <= 1'b1;
            WIRED_AUTO_CROSSOVER <= 1'b0;
        end else begin
            ASSOC_ENABLE <= boot_sampled && assoc_on;
            // without association the bridge runs once booted
            BRIDGE_ENABLE <= boot_sampled &&
                (!assoc_on || assoc_sync || ctrl[CTRL_ASSOC_BIT]);
            WIRED_GIGABIT <= 1'b1;
            WIRED_AUTO_CROSSOVER <= 1'b0;
        end
    end

    // =========================================================
    // apb slave: zero wait states, error on unmapped address
    assign apb_access = PSEL && PENABLE;
    assign apb_write = apb_access && PWRITE;
    assign apb_read = apb_access && !PWRITE;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ctrl <= CTRL_RESET;
            irq_mask <= IRQ_MASK_RESET;
        end else if (apb_write && PADDR == ADDR_CTRL) begin
            ctrl <= PWDATA[1:0];
        end else if (apb_write && PADDR == ADDR_IRQ_MASK) begin
            irq_mask <= PWDATA[IRQ_WIDTH-1:0];
        end
    end

    // events: detection latched, first and second reset steps
    assign irq_set[IRQ_DETECT_BIT] = (state == ST_READY) &&
        (next_state == ST_VACATED);
    assign irq_set[IRQ_RESET1_BIT] = (state == ST_VACATED) &&
        (next_state == ST_STEP1);
    assign irq_set[IRQ_RESET2_BIT] = (state == ST_STEP1) &&
        (next_state == ST_READY);

    // read clears status; a coincident event wins over the clear
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            irq_stat <= '0;
        end else if (apb_read && PADDR == ADDR_IRQ_STAT) begin
            // clear only what the read returned: a bit set at the
            // setup edge was not reported yet and must survive
            irq_stat <= irq_set |
                (irq_stat & ~PRDATA[IRQ_WIDTH-1:0]);
        end else begin
            irq_stat <= irq_stat | irq_set;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_stat & irq_mask);
        end
    end

    // read data registered in the setup phase, ready in the access
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            PRDATA <= 32'h0;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0;
            if (PSEL && !PENABLE) begin
                case (PADDR)
                    ADDR_CTRL: PRDATA <= {30'h0, ctrl};
                    ADDR_STATUS: PRDATA <= {22'h0, state, blink_phase,
                        assoc_sync, vacate_on, assoc_on, boot_sampled,
                        vacate_latched_state};
                    ADDR_IRQ_STAT: PRDATA <= {29'h0, irq_stat};
                    ADDR_IRQ_MASK: PRDATA <= {29'h0, irq_mask};
                    ADDR_RX_COUNT: PRDATA <= rx_count;
                    default: PSLVERR <= 1'b1;
                endcase
            end
        end
    end
endmodule

// [rtl/dvu_pkg.sv]
// package: constants and types shared by the detect-and-vacate user block
package dvu_pkg;
    // =========================================================
    // register map (byte addresses, one aligned word each)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
    localparam logic [7:0] ADDR_RX_COUNT = 8'h10;
    // ctrl fields
    localparam int CTRL_RETUNED_BIT = 0;
    localparam int CTRL_ASSOC_BIT = 1;
    // irq fields
    localparam int IRQ_DETECT_BIT = 0;
    localparam int IRQ_RESET1_BIT = 1;
    localparam int IRQ_RESET2_BIT = 2;
    localparam int IRQ_WIDTH = 3;
    // reset values
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    // =========================================================
    // timing
    localparam int CLOCK_HZ = 100000000;
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYCLES = CLOCK_HZ / 1000 * BLINK_MS;
    localparam int BOOT_SAMPLE_CYCLES = 4;
    // seven-segment style display codes, low nibble per digit
    localparam logic [3:0] DIGIT_ZERO = 4'h0;
    localparam logic [3:0] DIGIT_ONE = 4'h1;
    localparam logic [3:0] DIGIT_TWO = 4'h2;
    localparam logic [3:0] DIGIT_DASH = 4'ha;
    localparam int LINE_COUNT = 4;
    // vacate state machine
    typedef enum logic [3:0] {
        ST_READY = 4'b0001,
        ST_VACATED = 4'b0010,
        ST_STEP1 = 4'b0100,
        ST_DISABLED = 4'b1000
    } dvu_state_t;
endpackage

// [rtl/dvu_sync_if.sv]
// interface: synchronised user inputs passed from conditioner to core
`timescale 1ns/100ps
interface dvu_sync_if;
    logic [3:0] lines;
    logic reset_press;
    logic emulate_press;
    logic rx_pulse;
    logic [1:0] switches;
    modport src (output lines, reset_press, emulate_press, rx_pulse,
        switches);
    modport dst (input lines, reset_press, emulate_press, rx_pulse,
        switches);
endinterface

// [rtl/dvu_input_sync.sv]
// module: two-stage synchronisers and edge detection for pin inputs
`timescale 1ns/100ps
module dvu_input_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] lines_pin,
    input wire logic reset_btn_pin,
    input wire logic emulate_btn_pin,
    input wire logic rx_toggle_pin,
    input wire logic [1:0] switch_pin,
    dvu_sync_if.src sync
);
    import dvu_pkg::*;
    logic [8:0] meta;
    logic [8:0] stable;
    logic [2:0] last;
    logic [1:0] warm;

    // =========================================================
    // synchroniser: first stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= 9'h000;
            stable <= 9'h000;
        end else begin
            meta <= {switch_pin, rx_toggle_pin, emulate_btn_pin,
                reset_btn_pin, lines_pin};
            stable <= meta;
        end
    end

    // edge history for buttons and receive toggle; edges are held off
    // until the history holds a real pin level, since the toggle may
    // rest high through a reset and would fake a packet
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last <= 3'h0;
            warm <= 2'h0;
        end else begin
            last <= stable[6:4];
            if (warm != 2'h3) begin
                warm <= warm + 2'h1;
            end
        end
    end

    assign sync.lines = stable[3:0];
    // buttons act on the press edge so a held button counts once
    assign sync.reset_press = (warm == 2'h3) & stable[4] & ~last[0];
    assign sync.emulate_press = (warm == 2'h3) & stable[5] & ~last[1];
    // receive indication toggles once per packet; any change is one
    assign sync.rx_pulse = (warm == 2'h3) & (stable[6] ^ last[2]);
    assign sync.switches = stable[8:7];
endmodule

// [verification/dvu_core_props.sv]
// checker: port-level properties of the user block
`timescale 1ns/100ps
module dvu_core_props
    import dvu_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [3:0] GREEN_LED,
    input wire logic [3:0] RED_LED,
    input wire logic [3:0] DIGIT_LEFT,
    input wire logic [3:0] DIGIT_RIGHT,
    input wire logic DETECT_STATUS,
    input wire logic RETUNE_PRIMARY,
    input wire logic RETUNE_BACKUP,
    input wire logic ASSOC_ENABLE,
    input wire logic ASSOC_DONE,
    input wire logic WIRED_GIGABIT,
    input wire logic WIRED_AUTO_CROSSOVER
);
    // =========================================================
    // one clock domain, reset disables every check
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);
    sequence apb_setup_s;
        PSEL && !PENABLE;
    endsequence
    // red must settle a few cycles after leaving the vacated state
    sequence settled_s;
        !RETUNE_BACKUP [*3];
    endsequence
    wired_strap_a: assert property (
        WIRED_GIGABIT && !WIRED_AUTO_CROSSOVER)
        else $error("wired port straps wrong");
    apb_answer_a: assert property (apb_setup_s |=> PREADY)
        else $error("no ready one cycle after setup");
    err_zero_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
        else $error("error response without ready or with data");
    retune_pair_a: assert property (
        !$past(RST) |-> RETUNE_PRIMARY != RETUNE_BACKUP)
        else $error("primary and backup tuning not exclusive");
    status_cause_a: assert property (
        DETECT_STATUS |-> RETUNE_BACKUP)
        else $error("status high while not on backup channel");
    red_together_a: assert property (
        RED_LED == 4'h0 || RED_LED == 4'hf)
        else $error("red leds not lit together");
    red_idle_a: assert property (settled_s |-> RED_LED == 4'h0)
        else $error("red leds lit while not vacated");
    green_step_a: assert property (
        $changed(GREEN_LED) |-> GREEN_LED == $past(GREEN_LED) + 4'h1)
        else $error("green leds moved by other than one");
    step_one_a: assert property (
        $fell(RETUNE_BACKUP) |-> ##[0:2] DIGIT_LEFT == DIGIT_ONE)
        else $error("left digit not one after first reset press");
    assoc_shown_a: assert property (
        (ASSOC_ENABLE && ASSOC_DONE) [*8] |-> DIGIT_RIGHT == DIGIT_ONE)
        else $error("right digit not one while associated");
endmodule
bind dvu_core dvu_core_props u_props (.CLOCK(CLOCK), .RST(RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .GREEN_LED(GREEN_LED), .RED_LED(RED_LED),
    .DIGIT_LEFT(DIGIT_LEFT), .DIGIT_RIGHT(DIGIT_RIGHT),
    .DETECT_STATUS(DETECT_STATUS), .RETUNE_PRIMARY(RETUNE_PRIMARY),
    .RETUNE_BACKUP(RETUNE_BACKUP), .ASSOC_ENABLE(ASSOC_ENABLE),
    .ASSOC_DONE(ASSOC_DONE), .WIRED_GIGABIT(WIRED_GIGABIT),
    .WIRED_AUTO_CROSSOVER(WIRED_AUTO_CROSSOVER));

// [verification/dvu_detector_model.sv]
// model: detector board driving the four detection lines
`timescale 1ns/100ps
module dvu_detector_model #(
    parameter int HOLD_CYCLES = 25000000
) (
    input wire logic clk,
    input wire logic [3:0] band_enable,
    input wire logic [3:0] preamble,
    output logic [3:0] lines,
    output logic [3:0] band_led,
    output logic [3:0] red_led
);
    // counters start idle: monitoring needs no button action
    int band_cnt [4] = '{default: 0};
    int red_cnt = 0;
    // =========================================================
    // hold timers, shortened by the parameter in short runs
    always @(posedge clk) begin
        for (int b = 0; b < 4; b++) begin
            if (preamble[b] && band_enable[b]) begin
                band_cnt[b] <= HOLD_CYCLES;
            end else if (band_cnt[b] > 0) begin
                band_cnt[b] <= band_cnt[b] - 1;
            end
        end
        if (|(preamble & band_enable)) begin
            red_cnt <= HOLD_CYCLES;
        end else if (red_cnt > 0) begin
            red_cnt <= red_cnt - 1;
        end
    end
    // bit 0 is the lowest band and the bottom led
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            band_led[b] = band_cnt[b] != 0;
        end
    end
    assign lines = band_led;
    assign red_led = (red_cnt != 0) ? 4'hf : 4'h0;
endmodule

// [verification/tb_dvu_core.sv]
// testbench: user block against a detector board model
`timescale 1ns/100ps
module tb_dvu_core;
    import dvu_pkg::*;
    logic CLOCK = 1'b0;
    logic RST = 1'b1;
    logic RESET_BTN = 1'b0, EMULATE_BTN = 1'b0, RX_TOGGLE = 1'b0;
    logic ASSOC_DONE = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [1:0] BOOT_SWITCH = 2'h3;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic [3:0] DETECT_LINES, GREEN_LED, RED_LED, DIGIT_LEFT, DIGIT_RIGHT;
    logic [3:0] preamble = 4'h0, bands = 4'hf;
    logic PREADY, PSLVERR, DETECT_STATUS, RETUNE_PRIMARY, RETUNE_BACKUP;
    logic ASSOC_ENABLE, BRIDGE_ENABLE, WIRED_GIGABIT, WIRED_AUTO_CROSSOVER;
    logic IRQ, err;
    int n_errors = 0, compares = 0;
    always #5 CLOCK = ~CLOCK;
    dvu_core u_dut (.CLOCK(CLOCK), .RST(RST), .DETECT_LINES(DETECT_LINES),
        .RESET_BTN(RESET_BTN), .EMULATE_BTN(EMULATE_BTN),
        .RX_TOGGLE(RX_TOGGLE), .BOOT_SWITCH(BOOT_SWITCH),
        .ASSOC_DONE(ASSOC_DONE), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .GREEN_LED(GREEN_LED),
        .RED_LED(RED_LED), .DIGIT_LEFT(DIGIT_LEFT), .DIGIT_RIGHT(DIGIT_RIGHT),
        .DETECT_STATUS(DETECT_STATUS), .RETUNE_PRIMARY(RETUNE_PRIMARY),
        .RETUNE_BACKUP(RETUNE_BACKUP), .ASSOC_ENABLE(ASSOC_ENABLE),
        .BRIDGE_ENABLE(BRIDGE_ENABLE), .WIRED_GIGABIT(WIRED_GIGABIT),
        .WIRED_AUTO_CROSSOVER(WIRED_AUTO_CROSSOVER), .IRQ(IRQ));
    // short hold so the lines drop well inside one scenario
    dvu_detector_model #(.HOLD_CYCLES(40)) u_board (.clk(CLOCK),
        .band_enable(bands), .preamble(preamble), .lines(DETECT_LINES),
        .band_led(), .red_led());
    // =========================================================
    // checking and closing
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // =========================================================
    // apb master: request held until ready is seen at a rising edge
    task apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        int i;
        i = 0;
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        @(posedge CLOCK);
        while (PREADY !== 1'b1 && i < 20) begin
            @(posedge CLOCK);
            i++;
        end
        if (i == 20) begin
            n_errors++;
            stop_test();
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task wait_backup;
        int i;
        for (i = 0; i < 50 && RETUNE_BACKUP !== 1'b1; i++) @(negedge CLOCK);
        if (i == 50) begin
            n_errors++;
            stop_test();
        end
        repeat (3) @(posedge CLOCK);
    endtask
    task press(input logic emu);
        @(posedge CLOCK);
        if (emu) EMULATE_BTN <= 1'b1;
        else RESET_BTN <= 1'b1;
        repeat (6) @(posedge CLOCK);
        EMULATE_BTN <= 1'b0;
        RESET_BTN <= 1'b0;
        repeat (10) @(posedge CLOCK);
    endtask
    task pulse_band(input logic [3:0] b);
        preamble <= b;
        @(posedge CLOCK);
        preamble <= 4'h0;
    endtask
    // switches stay put from release until well after capture
    task do_reset(input logic [1:0] sw);
        RST <= 1'b1;
        BOOT_SWITCH <= sw;
        repeat (16) @(posedge CLOCK);
        chk({WIRED_GIGABIT, DIGIT_LEFT, DIGIT_RIGHT}, 9'h1aa);
        RST <= 1'b0;
        repeat (20) @(posedge CLOCK);
    endtask
    initial begin
        repeat (20000) @(posedge CLOCK);
        n_errors++;
        stop_test();
    end
    // =========================================================
    // main sequence
    initial begin
        do_reset(2'h3);
        chk(ASSOC_ENABLE, 1'b1);
        chk({DIGIT_LEFT, DIGIT_RIGHT}, {DIGIT_ZERO, DIGIT_ZERO});
        chk(BRIDGE_ENABLE, 1'b0);
        BOOT_SWITCH <= 2'h0;
        ASSOC_DONE <= 1'b1;
        repeat (12) @(posedge CLOCK);
        chk(ASSOC_ENABLE, 1'b1);
        chk({DIGIT_LEFT, DIGIT_RIGHT}, {DIGIT_ZERO, DIGIT_ONE});
        chk(BRIDGE_ENABLE, 1'b1);
        repeat (3) begin
            RX_TOGGLE <= ~RX_TOGGLE;
            repeat (5) @(posedge CLOCK);
        end
        repeat (6) @(posedge CLOCK);
        chk(GREEN_LED, 4'h3);
        apb(ADDR_RX_COUNT, 1'b0, 32'h0);
        chk(rd, 32'h3);
        apb(ADDR_CTRL, 1'b0, 32'h0);
        chk(rd, {30'h0, CTRL_RESET});
        apb(ADDR_CTRL, 1'b1, 32'h1);
        apb(ADDR_IRQ_MASK, 1'b1, 32'h7);
        apb(ADDR_IRQ_MASK, 1'b0, 32'h0);
        chk(rd, 32'h7);
        apb(8'h40, 1'b0, 32'h0);
        chk({31'h0, err} | rd, 32'h1);
        // real detection on the third band, vacate switch latched on
        pulse_band(4'h4);
        wait_backup();
        chk({DETECT_STATUS, RETUNE_PRIMARY, IRQ}, 3'h5);
        chk(RED_LED, 4'hf);
        apb(ADDR_IRQ_STAT, 1'b0, 32'h0);
        repeat (2) @(posedge CLOCK);
        chk({rd[0], IRQ}, 2'h2);
        press(1'b0);
        chk({DIGIT_LEFT, RETUNE_PRIMARY, DETECT_STATUS}, 6'h06);
        chk(RED_LED, 4'h0);
        pulse_band(4'h1);
        repeat (50) @(posedge CLOCK);
        chk(RETUNE_BACKUP, 1'b0);
        press(1'b0);
        chk(DIGIT_LEFT, DIGIT_TWO);
        apb(ADDR_IRQ_STAT, 1'b0, 32'h0);
        chk(rd[2:0], 3'h6);
        // emulated detection with every interrupt masked
        apb(ADDR_IRQ_MASK, 1'b1, 32'h0);
        press(1'b1);
        wait_backup();
        chk({DETECT_STATUS, IRQ}, 2'h2);
        press(1'b0);
        press(1'b0);
        chk({RETUNE_BACKUP, DIGIT_LEFT}, {1'b0, DIGIT_TWO});
        // top band switched off at the detector: its preamble is ignored
        bands <= 4'h7;
        pulse_band(4'h8);
        repeat (20) @(posedge CLOCK);
        chk(RETUNE_BACKUP, 1'b0);
        // association and vacate both off at the next boot
        do_reset(2'h0);
        chk({ASSOC_ENABLE, DIGIT_LEFT, DIGIT_RIGHT}, 9'h0aa);
        chk(GREEN_LED, 4'h0);
        press(1'b1);
        pulse_band(4'h1);
        repeat (20) @(posedge CLOCK);
        chk(RETUNE_BACKUP, 1'b0);
        stop_test();
    end
endmodule
